// >>> bdx_consts.vh
// Constants for the decimal-adjust, count-down, decrement, divide and exclusive-OR datapath.
`ifndef BDX_CONSTS_VH
`define BDX_CONSTS_VH
// Register map, word addresses on the Avalon-MM slave (byte address = 4 * index).
`define BDX_ADR_ACC 4'h0
`define BDX_ADR_IDXL 4'h1
`define BDX_ADR_IDXH 4'h2
`define BDX_ADR_FLAGS 4'h3
`define BDX_ADR_MEM 4'h4
`define BDX_ADR_PC 4'h5
`define BDX_ADR_REL 4'h6
`define BDX_ADR_CMD 4'h7
`define BDX_ADR_STATUS 4'h8
`define BDX_ADR_MEMRES 4'h9
// Flag register bit positions.
`define BDX_FLG_C 0
`define BDX_FLG_Z 1
`define BDX_FLG_N 2
`define BDX_FLG_I 3
`define BDX_FLG_H 4
`define BDX_FLG_V 7
// Flag register reset value: interrupt mask set, bits 6 and 5 read as one.
`define BDX_FLAGS_RST 8'h68
`define BDX_FLAGS_ONES 8'h60
// Operation codes written to the command register bits 2:0.
`define BDX_OP_ADJ 3'h0
`define BDX_OP_CDB 3'h1
`define BDX_OP_DEC 3'h2
`define BDX_OP_DIV 3'h3
`define BDX_OP_XOR 3'h4
// Operand targets in command register bits 5:4.
`define BDX_TGT_ACC 2'h0
`define BDX_TGT_IDX 2'h1
`define BDX_TGT_MEM 2'h2
// Addressing mode in command register bits 10:8.
`define BDX_MODE_DIR 3'h0
`define BDX_MODE_IX1 3'h1
`define BDX_MODE_INH 3'h2
`define BDX_MODE_IX 3'h3
`define BDX_MODE_SP1 3'h4
// Instruction lengths added to the program counter on a taken branch.
`define BDX_LEN_3 16'h0003
`define BDX_LEN_2 16'h0002
`define BDX_LEN_4 16'h0004
// Correction values of the decimal adjust.
`define BDX_COR_00 8'h00
`define BDX_COR_06 8'h06
`define BDX_COR_60 8'h60
`define BDX_COR_66 8'h66
// Overflow value of a decrement and the divide step count.
`define BDX_DEC_OVF 8'h80
`define BDX_DIV_STEPS 4'h8
`endif

// >>> bdx_bcd_fix.v
// Combinational correction selector for the decimal adjust.
`timescale 1ns/1ps
`default_nettype none
`include "bdx_consts.vh"
module bdx_bcd_fix (
    input wire [7:0] acc_i,
    input wire carry_i,
    input wire half_i,
    output reg [7:0] cor_o,
    output reg carry_o
);
    wire hi_a_f;
    wire hi_9_f;
    wire lo_a_f;
    assign hi_a_f = (acc_i[7:4] > 4'h9);
    assign hi_9_f = (acc_i[7:4] > 4'h8);
    assign lo_a_f = (acc_i[3:0] > 4'h9);
    // Combinations that no decimal sum can produce take the nearest row, not a fixed value.
    always @*
    begin
        cor_o = `BDX_COR_00;
        if (half_i || lo_a_f)
        begin
            cor_o = `BDX_COR_06; // see (RL1)
        end
        if (carry_i || hi_a_f || (hi_9_f && lo_a_f))
        begin
            cor_o = cor_o | `BDX_COR_60; // see (RL1)
        end
        carry_o = carry_i || cor_o[6]; // see (RL2)
    end
endmodule // bdx_bcd_fix
`default_nettype wire

// >>> bdx_div_step.v
// One restoring division step: shift in a dividend bit and trial-subtract the divisor.
`timescale 1ns/1ps
`default_nettype none
module bdx_div_step (
    input wire [8:0] rem_i,
    input wire bit_i,
    input wire [7:0] dvs_i,
    output wire [8:0] rem_o,
    output wire q_o
);
    wire [9:0] sh;
    wire [9:0] df;
    assign sh = {rem_i, bit_i};
    assign df = sh - {2'b00, dvs_i};
    assign q_o = ~df[9];
    assign rem_o = df[9] ? sh[8:0] : df[8:0];
endmodule // bdx_div_step
`default_nettype wire

// >>> bdx_alu.v
// Datapath for decimal adjust, count-down branch, decrement, divide and exclusive-OR.
`timescale 1ns/1ps
`default_nettype none
`include "bdx_consts.vh"
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// (RL1) Decimal adjust adds 00, 06, 60 or 66.
// (RL2) Adjust carry set for 60/66; kept if set.
// (RL3) Only decimal-sum inputs have defined results.
// (RL4) Count-down branch decrements, branches if nonzero, flags kept.
// (RL5) Branch target: pc plus length 2/3/4 plus offset.
// (RL6) Index count-down touches only the low byte.
// (RL7) Decrement updates V, N, Z; carry untouched.
// (RL8) Decrement overflow exactly when operand was 80.
// (RL9) Index decrement keeps the high byte.
// (RL10) N from bit 7, Z on zero result.
// (RL11) Divide high-index:acc by index low, unsigned.
// (RL12) Quotient to acc, remainder to high index.
// (RL13) Carry on zero divisor or quotient overflow.
// (RL14) Divide Z from quotient; V H I N kept.
// (RL15) Exclusive-OR into acc, V cleared, C H kept.
// (RL16) Branch offset is sign-extended two's complement.
module bdx_alu (
    input wire CORE_CLK_I,
    input wire RST_B_I,
    input wire [5:0] AVS_ADDRESS_I,
    input wire AVS_READ_I,
    input wire AVS_WRITE_I,
    input wire [31:0] AVS_WRITEDATA_I,
    input wire [3:0] AVS_BYTEENABLE_I,
    output reg [31:0] AVS_READDATA_O,
    output wire AVS_WAITREQUEST_O
);
    localparam ST_IDLE = 3'b001;
    localparam ST_DIV = 3'b010;
    localparam ST_ACK = 3'b100;
    reg [2:0] state_r;
    reg [7:0] acc_r;
    reg [7:0] idxl_r;
    reg [7:0] idxh_r;
    reg [7:0] flags_r;
    reg [7:0] mem_r;
    reg [15:0] pc_r;
    reg [7:0] rel_r;
    reg [10:0] cmd_r;
    reg busy_r;
    reg taken_r;
    reg [7:0] quo_r;
    reg [8:0] rem_r;
    reg [3:0] cnt_r;
    reg [15:0] dvd_r;
    reg ack_r;
    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode. Every access waits at least one cycle so read data always come from a flop.
    wire [3:0] word;
    wire wr_hit;
    wire go;
    assign word = AVS_ADDRESS_I[5:2];
    assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack_r;
    assign wr_hit = AVS_WRITE_I && !ack_r && AVS_BYTEENABLE_I[0];
    assign go = wr_hit && (word == `BDX_ADR_CMD) && !busy_r;
    ////////////////////////////////////////////////////////////////////////////////
    // Operand selection.
    wire [2:0] op;
    wire [1:0] tgt;
    wire [2:0] mode;
    wire [7:0] opnd;
    wire [7:0] dec_res;
    wire [7:0] cor;
    wire adj_c;
    wire [7:0] adj_res;
    wire [7:0] xor_res;
    reg [15:0] len;
    wire [15:0] target;
    assign op = AVS_WRITEDATA_I[2:0];
    assign tgt = AVS_WRITEDATA_I[5:4];
    assign mode = AVS_WRITEDATA_I[10:8];
    assign opnd = (tgt == `BDX_TGT_IDX) ? idxl_r : ((tgt == `BDX_TGT_MEM) ? mem_r : acc_r);
    assign dec_res = opnd - 8'h01;
    assign adj_res = acc_r + cor;
    assign xor_res = acc_r ^ mem_r;
    always @*
    begin
        case (mode)
            `BDX_MODE_DIR, `BDX_MODE_IX1: len = `BDX_LEN_3; // see (RL5)
            `BDX_MODE_INH, `BDX_MODE_IX: len = `BDX_LEN_2; // see (RL5)
            `BDX_MODE_SP1: len = `BDX_LEN_4; // see (RL5)
            default: len = `BDX_LEN_2;
        endcase
    end
    assign target = pc_r + len + {{8{rel_r[7]}}, rel_r}; // see (RL5) see (RL16)
    bdx_bcd_fix u_fix (
        .acc_i(acc_r),
        .carry_i(flags_r[`BDX_FLG_C]),
        .half_i(flags_r[`BDX_FLG_H]),
        .cor_o(cor),
        .carry_o(adj_c)
    );
    ////////////////////////////////////////////////////////////////////////////////
    // Division, one quotient bit per cycle over eight cycles.
    wire [8:0] rem_nxt;
    wire q_bit;
    wire div_ovf;
    bdx_div_step u_step (
        .rem_i(rem_r),
        .bit_i(dvd_r[7]),
        .dvs_i(idxl_r),
        .rem_o(rem_nxt),
        .q_o(q_bit)
    );
    // A high part at or above the divisor means the quotient cannot fit eight bits.
    assign div_ovf = (idxl_r == 8'h00) || (idxh_r >= idxl_r); // see (RL13)
    wire div_go;
    wire div_last;
    assign div_go = go && (op == `BDX_OP_DIV);
    assign div_last = (cnt_r == `BDX_DIV_STEPS - 4'h1);
    ////////////////////////////////////////////////////////////////////////////////
    // Divider registers. The whole dividend is shifted but only its low byte feeds the step; the high byte seeds the remainder.
    always @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            quo_r <= 8'h00;
            rem_r <= 9'h000;
            cnt_r <= 4'h0;
            dvd_r <= 16'h0000;
        end
        else if (state_r == ST_IDLE)
        begin
            if (div_go)
            begin
                dvd_r <= {idxh_r, acc_r}; // see (RL11)
                rem_r <= {1'b0, idxh_r}; // see (RL11)
                cnt_r <= 4'h0;
            end
        end
        else if (state_r == ST_DIV)
        begin
            rem_r <= rem_nxt;
            quo_r <= {quo_r[6:0], q_bit};
            dvd_r <= {dvd_r[14:0], 1'b0};
            cnt_r <= cnt_r + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Bus answer. A divide keeps its own write waiting until the write-back cycle.
    always @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            ack_r <= 1'b0;
        end
        else if (state_r == ST_ACK)
        begin
            ack_r <= 1'b1;
        end
        else
        begin
            ack_r <= (AVS_READ_I || AVS_WRITE_I) && !ack_r && !busy_r && !div_go;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Architectural state and instruction execution.
    always @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            state_r <= ST_IDLE;
            acc_r <= 8'h00;
            idxl_r <= 8'h00;
            idxh_r <= 8'h00;
            flags_r <= `BDX_FLAGS_RST;
            mem_r <= 8'h00;
            pc_r <= 16'h0000;
            rel_r <= 8'h00;
            cmd_r <= 11'h000;
            busy_r <= 1'b0;
            taken_r <= 1'b0;
        end
        else
        begin
            if (wr_hit && !busy_r)
            begin
                case (word)
                    `BDX_ADR_ACC: acc_r <= AVS_WRITEDATA_I[7:0];
                    `BDX_ADR_IDXL: idxl_r <= AVS_WRITEDATA_I[7:0];
                    `BDX_ADR_IDXH: idxh_r <= AVS_WRITEDATA_I[7:0];
                    `BDX_ADR_FLAGS: flags_r <= AVS_WRITEDATA_I[7:0] | `BDX_FLAGS_ONES;
                    `BDX_ADR_MEM: mem_r <= AVS_WRITEDATA_I[7:0];
                    `BDX_ADR_PC: pc_r <= AVS_WRITEDATA_I[15:0];
                    `BDX_ADR_REL: rel_r <= AVS_WRITEDATA_I[7:0];
                    default: ;
                endcase
            end
            case (state_r)
                ST_IDLE:
                begin
                    if (go)
                    begin
                        cmd_r <= AVS_WRITEDATA_I[10:0];
                        taken_r <= 1'b0;
                        case (op)
                            `BDX_OP_ADJ:
                            begin
                                // Non-decimal inputs give a result but no promise. see (RL3)
                                acc_r <= adj_res; // see (RL1)
                                flags_r[`BDX_FLG_C] <= adj_c; // see (RL2)
                                flags_r[`BDX_FLG_N] <= adj_res[7]; // see (RL10)
                                flags_r[`BDX_FLG_Z] <= (adj_res == 8'h00); // see (RL10)
                            end
                            `BDX_OP_CDB, `BDX_OP_DEC:
                            begin
                                if (tgt == `BDX_TGT_IDX)
                                begin
                                    idxl_r <= dec_res; // see (RL6) see (RL9)
                                end
                                else if (tgt == `BDX_TGT_MEM)
                                begin
                                    mem_r <= dec_res; // see (RL4)
                                end
                                else
                                begin
                                    acc_r <= dec_res; // see (RL4) see (RL7)
                                end
                                if (op == `BDX_OP_CDB)
                                begin
                                    if (dec_res != 8'h00)
                                    begin
                                        pc_r <= target; // see (RL4) see (RL5)
                                        taken_r <= 1'b1;
                                    end
                                end
                                else
                                begin
                                    flags_r[`BDX_FLG_V] <= (opnd == `BDX_DEC_OVF); // see (RL8)
                                    flags_r[`BDX_FLG_N] <= dec_res[7]; // see (RL10)
                                    flags_r[`BDX_FLG_Z] <= (dec_res == 8'h00); // see (RL10)
                                end
                            end
                            `BDX_OP_DIV:
                            begin
                                busy_r <= 1'b1;
                                state_r <= ST_DIV;
                            end
                            `BDX_OP_XOR:
                            begin
                                acc_r <= xor_res; // see (RL15)
                                flags_r[`BDX_FLG_V] <= 1'b0; // see (RL15)
                                flags_r[`BDX_FLG_N] <= xor_res[7]; // see (RL10)
                                flags_r[`BDX_FLG_Z] <= (xor_res == 8'h00); // see (RL10)
                            end
                            default: ;
                        endcase
                    end
                end
                ST_DIV:
                begin
                    if (div_last)
                    begin
                        state_r <= ST_ACK;
                    end
                end
                ST_ACK:
                begin
                    acc_r <= quo_r; // see (RL12)
                    idxh_r <= rem_r[7:0]; // see (RL12)
                    flags_r[`BDX_FLG_C] <= div_ovf; // see (RL13)
                    flags_r[`BDX_FLG_Z] <= (quo_r == 8'h00); // see (RL14)
                    busy_r <= 1'b0;
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Read data register. Unmapped words read as zero.
    always @(posedge CORE_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            AVS_READDATA_O <= 32'h00000000;
        end
        else if (AVS_READ_I && !ack_r)
        begin
            case (word)
                `BDX_ADR_ACC: AVS_READDATA_O <= {24'h000000, acc_r};
                `BDX_ADR_IDXL: AVS_READDATA_O <= {24'h000000, idxl_r};
                `BDX_ADR_IDXH: AVS_READDATA_O <= {24'h000000, idxh_r};
                `BDX_ADR_FLAGS: AVS_READDATA_O <= {24'h000000, flags_r};
                `BDX_ADR_MEM: AVS_READDATA_O <= {24'h000000, mem_r};
                `BDX_ADR_PC: AVS_READDATA_O <= {16'h0000, pc_r};
                `BDX_ADR_REL: AVS_READDATA_O <= {24'h000000, rel_r};
                `BDX_ADR_CMD: AVS_READDATA_O <= {21'h000000, cmd_r};
                `BDX_ADR_STATUS: AVS_READDATA_O <= {30'h00000000, taken_r, busy_r};
                default: AVS_READDATA_O <= 32'h00000000;
            endcase
        end
    end
endmodule // bdx_alu
`default_nettype wire

// >>> bdx_alu_checker.sv
// Port checks for the datapath's register bus.
`timescale 1ns/1ps
`default_nettype none
module bdx_alu_checker (
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    input wire logic [5:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic AVS_WAITREQUEST_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_B_I);
    wire [3:0] ix = AVS_ADDRESS_I[5:2];
    wire ack = AVS_READ_I && !AVS_WAITREQUEST_O;
    // A divide only starts when the low byte lane is enabled.
    wire dv = AVS_WRITE_I && ix == 4'h7 && AVS_WRITEDATA_I[2:0] == 3'h3 && AVS_BYTEENABLE_I[0];
    ////////////////////////////////////////////////////////////////////////////
    chk_div_wait: assert property ($rose(AVS_WRITE_I) && dv
        |-> AVS_WAITREQUEST_O [*8] ##[2:3] !AVS_WAITREQUEST_O) else $error("divide answer timing");
    chk_write_ack: assert property ($rose(AVS_WRITE_I) && !dv |=> !AVS_WAITREQUEST_O)
        else $error("write answer late");
    chk_read_ack: assert property ($rose(AVS_READ_I) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
        else $error("read answer timing");
    chk_idle_free: assert property (!AVS_READ_I && !AVS_WRITE_I |-> !AVS_WAITREQUEST_O)
        else $error("wait without request");
    chk_rdata_hold: assert property (!AVS_READ_I |=> $stable(AVS_READDATA_O))
        else $error("read data moved without read");
    chk_resv_zero: assert property (ack && ix >= 4'h9 |-> AVS_READDATA_O == 32'h0)
        else $error("reserved read not zero");
    chk_flag_ones: assert property (ack && ix == 4'h3
        |-> AVS_READDATA_O[6:5] == 2'b11 && AVS_READDATA_O[31:8] == 24'h0) else $error("flag format");
    chk_byte_wide: assert property (ack && ix <= 4'h6 && ix != 4'h5
        |-> AVS_READDATA_O[31:8] == 24'h0) else $error("byte register too wide");
    chk_stat_idle: assert property (ack && ix == 4'h8
        |-> AVS_READDATA_O[31:2] == 30'h0 && !AVS_READDATA_O[0]) else $error("status format");
    cover property ($rose(AVS_WRITE_I) && dv);
    cover property (ack && ix == 4'h8 && AVS_READDATA_O[1]);
    cover property (ack && ix == 4'h9);
endmodule // bdx_alu_checker
bind bdx_alu bdx_alu_checker i_chk (.CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O));
`default_nettype wire

// >>> bdx_alu_bench.sv
// Self-checking bench: an integer model of the registers is compared after every command.
`timescale 1ns/1ps
`default_nettype none
`include "bdx_consts.vh"
module bdx_alu_bench;
    logic CORE_CLK_I = 1'b0;
    logic RST_B_I = 1'b0;
    logic [5:0] AVS_ADDRESS_I = 6'h00;
    logic AVS_READ_I = 1'b0;
    logic AVS_WRITE_I = 1'b0;
    logic [31:0] AVS_WRITEDATA_I = 32'h0;
    logic [3:0] AVS_BYTEENABLE_I = 4'hf;
    logic [31:0] AVS_READDATA_O;
    logic AVS_WAITREQUEST_O;
    integer fails = 0;
    integer checks_done = 0;
    integer m [0:15];
    integer msk [0:15];
    logic [31:0] lf = 32'h5b5c;
    logic [31:0] q;
    logic [7:0] f;
    integer a, c, h, v, i, t, r, x;
    always #12.5 CORE_CLK_I = ~CORE_CLK_I;
    bdx_alu i_dut (.CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
        .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
        .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
        .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O));
    ////////////////////////////////////////////////////////////////////////////
    function automatic [31:0] nx(input [31:0] s);
        nx = {1'b0, s[31:1]} ^ (s[0] ? 32'hedb88320 : 32'h0);
    endfunction
    // One bus access; the request is held until waitrequest is seen low at a rising edge.
    task automatic bus(input logic wr, input logic [3:0] ix, input logic [31:0] d);
        integer n;
        begin
            @(posedge CORE_CLK_I);
            lf = nx(lf);
            AVS_ADDRESS_I <= {ix, 2'b00};
            AVS_WRITEDATA_I <= d;
            AVS_BYTEENABLE_I <= {lf[2:0], 1'b1};
            AVS_READ_I <= !wr;
            AVS_WRITE_I <= wr;
            n = 0;
            @(posedge CORE_CLK_I);
            while (AVS_WAITREQUEST_O !== 1'b0 && n < 40)
            begin
                n = n + 1;
                @(posedge CORE_CLK_I);
            end
            if (n >= 40)
            begin
                $display("wrong value waitrequest expected 0 seen 1");
                fails = fails + 1;
                complete_run;
            end
            q = AVS_READDATA_O;
            AVS_READ_I <= 1'b0;
            AVS_WRITE_I <= 1'b0;
        end
    endtask
    task automatic put(input integer ix, input integer d);
        begin
            bus(1'b1, ix[3:0], d);
            m[ix] = (ix == 3) ? (d & 8'hff) | 8'h60 : d & ((ix == 5) ? 16'hffff : 8'hff);
        end
    endtask
    // Issues a command and records the bits that the command word keeps.
    task automatic run(input integer cmd);
        begin
            m[7] = cmd & 32'h7ff;
            bus(1'b1, `BDX_ADR_CMD, cmd);
        end
    endtask
    // Reads every word and compares it with the model under its mask.
    task automatic check_all;
        integer k;
        begin
            for (k = 0; k < 16; k = k + 1)
            begin
                bus(1'b0, k[3:0], 32'h0);
                checks_done = checks_done + 1;
                if ((q & msk[k]) !== (m[k] & msk[k]))
                begin
                    fails = fails + 1;
                    $display("wrong value word %0d expected %h seen %h", k, m[k] & msk[k], q & msk[k]);
                end
            end
        end
    endtask
    task automatic nz(input integer res);
        begin
            f = m[3][7:0];
            f[`BDX_FLG_N] = res[7];
            f[`BDX_FLG_Z] = (res == 0);
        end
    endtask
    task automatic roll_flags;
        begin
            lf = nx(lf);
            put(3, lf[7:0]);
        end
    endtask
    task automatic complete_run;
        begin
            $display("checks %0d mismatches %0d", checks_done, fails);
            if (fails == 0 && checks_done > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial
    begin
        #1500000;
        fails = fails + 1;
        complete_run;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (i = 0; i < 16; i = i + 1)
        begin
            m[i] = 0;
            msk[i] = (i == 8) ? 1 : 32'hffffffff;
        end
        m[3] = `BDX_FLAGS_RST;
        repeat (6) @(posedge CORE_CLK_I);
        RST_B_I <= 1'b1;
        check_all;
        $display("reset test done");
        // Only sums that decimal addition can produce are driven; the rest is undefined.
        for (i = 0; i < 1024; i = i + 1)
        begin
            a = i % 256;
            h = (i / 256) % 2;
            c = i / 512;
            if ((h == 0 || a % 16 <= 3) && (c == 0 || a / 16 <= (h ? 3 : 2)))
            begin
                put(0, a);
                lf = nx(lf);
                put(3, (c << `BDX_FLG_C) | (h << `BDX_FLG_H) | (lf[7:0] & 8'hee));
                r = ((h || a % 16 > 9) ? 6 : 0) + ((c || a > 153) ? 96 : 0);
                m[0] = (a + r) % 256;
                nz(m[0]);
                f[`BDX_FLG_C] = (r >= 96);
                m[3] = f;
                run(`BDX_OP_ADJ);
                msk[3] = 32'h7f;
                check_all;
            end
        end
        msk[3] = 32'hffffffff;
        $display("adjust test done");
        for (t = 0; t < 15; t = t + 1)
        begin
            lf = nx(lf);
            v = (t % 5 == 0) ? 1 : (t % 5 == 1) ? 0 : lf[7:0];
            x = (t % 3 == 0) ? 0 : (t % 3 == 1) ? 1 : 4;
            put(x, v);
            put(2, lf[15:8]);
            put(5, lf[31:16]);
            put(6, lf[23:16]);
            roll_flags;
            r = (v + 255) % 256;
            m[x] = r;
            if (r != 0)
                m[5] = (m[5] + ((t / 3 == 2 || t / 3 == 3) ? 2 : (t / 3 == 4) ? 4 : 3) + m[6]
                    - (m[6] >= 128 ? 256 : 0)) & 32'hffff;
            m[8] = (r != 0) << 1;
            msk[8] = 3;
            run(((t / 3) << 8) | ((t % 3) << 4) | `BDX_OP_CDB);
            check_all;
        end
        msk[8] = 1;
        $display("count down test done");
        for (t = 0; t < 12; t = t + 1)
        begin
            lf = nx(lf);
            v = (t < 3) ? 128 : (t < 6) ? 0 : (t < 9) ? 1 : lf[7:0];
            x = (t % 3 == 0) ? 0 : (t % 3 == 1) ? 1 : 4;
            put(x, v);
            put(2, lf[15:8]);
            roll_flags;
            m[x] = (v + 255) % 256;
            nz(m[x]);
            f[`BDX_FLG_V] = (v == 128);
            m[3] = f;
            run(((t % 3) << 4) | (2 << 8) | `BDX_OP_DEC);
            check_all;
        end
        $display("decrement test done");
        for (t = 0; t < 20; t = t + 1)
        begin
            lf = nx(lf);
            x = (t == 0) ? 0 : (t == 1) ? 100 : lf[7:0] | 1;
            h = (t == 1) ? 200 : lf[15:8] % (x == 0 ? 1 : x);
            a = (t == 2) ? 0 : lf[23:16];
            put(2, h);
            put(0, a);
            put(1, x);
            roll_flags;
            f = m[3][7:0];
            // After an error the quotient, remainder and zero flag are not defined.
            if (x == 0 || (h * 256 + a) / x > 255)
            begin
                f[`BDX_FLG_C] = 1'b1;
                msk[0] = 0;
                msk[2] = 0;
                msk[3] = 32'hfffffffd;
            end
            else
            begin
                m[0] = (h * 256 + a) / x;
                m[2] = (h * 256 + a) % x;
                f[`BDX_FLG_C] = 1'b0;
                f[`BDX_FLG_Z] = (m[0] == 0);
            end
            m[3] = f;
            run((2 << 8) | `BDX_OP_DIV);
            check_all;
            msk[0] = 32'hffffffff;
            msk[2] = 32'hffffffff;
            msk[3] = 32'hffffffff;
        end
        $display("divide test done");
        for (t = 0; t < 8; t = t + 1)
        begin
            lf = nx(lf);
            put(0, lf[7:0]);
            put(4, (t == 0) ? m[0] : lf[15:8]);
            roll_flags;
            m[0] = m[0] ^ m[4];
            nz(m[0]);
            f[`BDX_FLG_V] = 1'b0;
            m[3] = f;
            run((2 << 8) | (2 << 4) | `BDX_OP_XOR);
            check_all;
        end
        $display("xor test done");
        complete_run;
    end
endmodule // bdx_alu_bench
`default_nettype wire
